// File: src/mpfs_pkg.sv
// Shared types and constants for the mode pin function select block
package mpfs_pkg;

	// Depth of every pin synchroniser
	localparam int MPFS_SYNC_STAGES = 2;
	// Cycles counted after reset before the synchronised mode pins are sampled and locked
	localparam logic [3:0] MPFS_MODE_SETTLE = 4'h4;
	// Reset value of the settle counter
	localparam logic [3:0] MPFS_SETTLE_RST = 4'h0;
	// Reset value of every routed one-bit output
	localparam logic MPFS_BIT_RST = 1'b0;

	// Decoded operating mode, fixed once locked
	typedef struct packed {
		logic ext_step;   // Step and direction come from pins
		logic spi_on;     // Four-wire serial host port active
		logic uart_on;    // Single-wire host port active
		logic standalone; // Shared pins act as configuration straps
	} mpfs_mode_t;

	// Reset value of the decoded mode
	localparam mpfs_mode_t MPFS_MODE_RST = '0;

	// All pins that enter from outside, in synchroniser bit order
	typedef struct packed {
		logic step_sel;  // Step source select
		logic host_sel;  // Host port select
		logic left;      // Left reference or step
		logic right;     // Right reference or direction
		logic sdi;       // Serial in or config 1
		logic sck;       // Serial clock or config 2
		logic encb;      // Encoder B or speed control enable
		logic sdo;       // Serial out pin read back as config 0
	} mpfs_pins_t;

	// Static configuration straps sampled in standalone mode
	typedef struct packed {
		logic cfg4; // Encoder B pin as strap
		logic cfg2; // Serial clock pin as strap
		logic cfg1; // Serial in pin as strap
		logic cfg0; // Serial out pin as strap
	} mpfs_cfg_t;

	// Reset value of the straps
	localparam mpfs_cfg_t MPFS_CFG_RST = '0;

	// Lock state of the mode capture
	typedef enum logic {
		MPFS_SETTLING,
		MPFS_LOCKED
	} mpfs_lock_t;

endpackage

// File: src/mpfs_sync.sv
// Two flip-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module mpfs_sync
	import mpfs_pkg::*;
#(
	parameter int WIDTH = 8 // Number of pins
) (
	input wire logic core_clk, // Device clock
	input wire logic reset, // Asynchronous reset, active high
	input wire logic [WIDTH-1:0] pin_in, // Raw pins
	output logic [WIDTH-1:0] pin_sync // Synchronised pins
);

	genvar i;

	// One chain per pin; the first stage feeds only the second
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta; // First stage, read by the second only
			logic next_meta; // Next first stage
			logic next_sync; // Next second stage
			// Next values
			always_comb begin
				next_meta = pin_in[i];
				next_sync = meta;
			end
			// Registers
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					meta <= MPFS_BIT_RST;
					pin_sync[i] <= MPFS_BIT_RST;
				end else begin
					meta <= next_meta;
					pin_sync[i] <= next_sync;
				end
			end
		end
	endgenerate

endmodule

// File: src/mpfs_mode_latch.sv
// Captures the two mode pins after reset and holds the decoded mode
`timescale 1ns/1ps
module mpfs_mode_latch
	import mpfs_pkg::*;
(
	input wire logic core_clk, // Device clock
	input wire logic reset, // Asynchronous reset, active high
	input wire logic step_sel_s, // Synchronised step source select
	input wire logic host_sel_s, // Synchronised host port select
	output mpfs_mode_t mode, // Locked mode
	output logic mode_valid // Mode is locked
);

	mpfs_lock_t state; // Lock state
	mpfs_lock_t next_state; // Next lock state
	logic [3:0] settle; // Cycles of settling done
	logic [3:0] next_settle; // Next settle count
	mpfs_mode_t next_mode; // Next locked mode

	// Settle, then decode once; the pins are straps and later moves are ignored
	always_comb begin
		next_state = state;
		next_settle = settle;
		next_mode = mode;
		unique case (state)
			MPFS_SETTLING: begin
				if (settle == MPFS_MODE_SETTLE) begin
					next_state = MPFS_LOCKED;
					next_mode.ext_step = step_sel_s;
					next_mode.spi_on = host_sel_s;
					next_mode.uart_on = !step_sel_s && !host_sel_s;
					next_mode.standalone = step_sel_s && !host_sel_s;
				end else begin
					next_settle = settle + 4'h1;
				end
			end
			MPFS_LOCKED: begin
				next_mode = mode;
			end
		endcase
	end

	// Registers
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= MPFS_SETTLING;
			settle <= MPFS_SETTLE_RST;
			mode <= MPFS_MODE_RST;
		end else begin
			state <= next_state;
			settle <= next_settle;
			mode <= next_mode;
		end
	end

	assign mode_valid = (state == MPFS_LOCKED);

endmodule

// File: src/mpfs_pin_mux.sv
// Pin function multiplexer steered by the two static mode pins
`timescale 1ns/1ps

module mpfs_pin_mux
	import mpfs_pkg::*;
(
	input wire logic core_clk, // Device clock, 40 MHz
	input wire logic reset, // Asynchronous reset, active high
	input wire logic step_source_select, // Step source select pin
	input wire logic host_port_select, // Host port select pin, pulled down
	input wire logic left_ref_or_step_pin, // Left reference or step pin
	input wire logic right_ref_or_dir_pin, // Right reference or direction pin
	input wire logic serial_in_or_config1_pin, // Serial in or strap pin
	input wire logic serial_clock_or_config2_pin, // Serial clock or strap pin
	input wire logic encoder_b_or_speedctl_enable_pin, // Encoder B or enable pin
	input wire logic serial_out_or_config0_pin_in, // Serial out pin level
	output logic serial_out_or_config0_pin_out, // Serial out pin drive value
	output logic serial_out_or_config0_pin_oe, // Serial out pin drive enable
	input wire logic ramp_step, // Step from ramp generator
	input wire logic ramp_dir, // Direction from ramp generator
	input wire logic spi_sdo_data, // Serial port output bit
	input wire logic spi_sdo_active, // Serial port wants the output pin
	input wire logic chain_address_out, // Chain output from single-wire port
	output logic drv_step, // Step to motor driver
	output logic drv_dir, // Direction to motor driver
	output logic ref_left, // Left limit switch to ramp generator
	output logic ref_right, // Right limit switch to ramp generator
	output logic encoder_b, // Encoder B channel
	output logic speedctl_enable, // Load-dependent speed control enable
	output logic spi_sdi, // Serial port data in
	output logic spi_sck, // Serial port clock
	output logic chain_address_in, // Chain input to single-wire port
	output mpfs_cfg_t cfg, // Standalone straps
	output mpfs_mode_t mode, // Locked mode
	output logic mode_valid // Mode locked, routing active
);

	mpfs_pins_t pins_raw; // Pins gathered for the synchroniser
	mpfs_pins_t pins_s; // Synchronised pins
	logic [$bits(mpfs_pins_t)-1:0] pins_s_vec; // Synchroniser output

	// Gather raw pins in struct order
	assign pins_raw.step_sel = step_source_select;
	assign pins_raw.host_sel = host_port_select;
	assign pins_raw.left = left_ref_or_step_pin;
	assign pins_raw.right = right_ref_or_dir_pin;
	assign pins_raw.sdi = serial_in_or_config1_pin;
	assign pins_raw.sck = serial_clock_or_config2_pin;
	assign pins_raw.encb = encoder_b_or_speedctl_enable_pin;
	assign pins_raw.sdo = serial_out_or_config0_pin_in;

	// Every pin crosses two flops before any routing looks at it
	mpfs_sync #(
		.WIDTH($bits(mpfs_pins_t))
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.pin_in(pins_raw),
		.pin_sync(pins_s_vec)
	);

	assign pins_s = mpfs_pins_t'(pins_s_vec);

	// Mode pins are straps; a late change would reroute pins mid-motion
	mpfs_mode_latch u_mode (
		.core_clk(core_clk),
		.reset(reset),
		.step_sel_s(pins_s.step_sel),
		.host_sel_s(pins_s.host_sel),
		.mode(mode),
		.mode_valid(mode_valid)
	);

	logic next_drv_step; // Next driver step
	logic next_drv_dir; // Next driver direction
	logic next_ref_left; // Next left switch
	logic next_ref_right; // Next right switch
	logic next_encoder_b; // Next encoder B
	logic next_speedctl_enable; // Next speed control enable
	logic next_spi_sdi; // Next serial data in
	logic next_spi_sck; // Next serial clock
	logic next_chain_in; // Next chain input
	mpfs_cfg_t next_cfg; // Next straps
	logic next_sdo_out; // Next serial out drive value
	logic next_sdo_oe; // Next serial out drive enable

	// Route every shared pin; nothing is driven until the mode is locked
	always_comb begin
		next_drv_step = MPFS_BIT_RST;
		next_drv_dir = MPFS_BIT_RST;
		next_ref_left = MPFS_BIT_RST;
		next_ref_right = MPFS_BIT_RST;
		next_encoder_b = MPFS_BIT_RST;
		next_speedctl_enable = MPFS_BIT_RST;
		next_spi_sdi = MPFS_BIT_RST;
		next_spi_sck = MPFS_BIT_RST;
		next_chain_in = MPFS_BIT_RST;
		next_cfg = MPFS_CFG_RST;
		next_sdo_out = MPFS_BIT_RST;
		next_sdo_oe = MPFS_BIT_RST;
		if (mode_valid) begin
			// Motion source
			if (mode.ext_step) begin
				// Pins drive the motor; switch inputs read as open
				next_drv_step = pins_s.left;
				next_drv_dir = pins_s.right;
			end else begin
				// Ramp generator drives; pin levels go to the switches and encoder B only
				next_drv_step = ramp_step;
				next_drv_dir = ramp_dir;
				next_ref_left = pins_s.left;
				next_ref_right = pins_s.right;
				next_encoder_b = pins_s.encb;
			end
			// Speed control needs both external steps and the serial port
			if (mode.ext_step && mode.spi_on) begin
				next_speedctl_enable = pins_s.encb;
			end
			// Host port
			if (mode.spi_on) begin
				next_spi_sdi = pins_s.sdi;
				next_spi_sck = pins_s.sck;
				// Pin floats while the port is not answering
				next_sdo_out = spi_sdo_data;
				next_sdo_oe = spi_sdo_active;
			end else if (mode.uart_on) begin
				next_chain_in = pins_s.sdi;
				next_sdo_out = chain_address_out;
				next_sdo_oe = 1'b1;
			end else begin
				// Standalone: all shared serial pins are straps
				next_cfg.cfg0 = pins_s.sdo;
				next_cfg.cfg1 = pins_s.sdi;
				next_cfg.cfg2 = pins_s.sck;
				next_cfg.cfg4 = pins_s.encb;
			end
		end
	end

	// Routed outputs all come from flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			drv_step <= MPFS_BIT_RST;
			drv_dir <= MPFS_BIT_RST;
			ref_left <= MPFS_BIT_RST;
			ref_right <= MPFS_BIT_RST;
			encoder_b <= MPFS_BIT_RST;
			speedctl_enable <= MPFS_BIT_RST;
			spi_sdi <= MPFS_BIT_RST;
			spi_sck <= MPFS_BIT_RST;
			chain_address_in <= MPFS_BIT_RST;
			cfg <= MPFS_CFG_RST;
			serial_out_or_config0_pin_out <= MPFS_BIT_RST;
			serial_out_or_config0_pin_oe <= MPFS_BIT_RST;
		end else begin
			drv_step <= next_drv_step;
			drv_dir <= next_drv_dir;
			ref_left <= next_ref_left;
			ref_right <= next_ref_right;
			encoder_b <= next_encoder_b;
			speedctl_enable <= next_speedctl_enable;
			spi_sdi <= next_spi_sdi;
			spi_sck <= next_spi_sck;
			chain_address_in <= next_chain_in;
			cfg <= next_cfg;
			serial_out_or_config0_pin_out <= next_sdo_out;
			serial_out_or_config0_pin_oe <= next_sdo_oe;
		end
	end

	// Ramp steps reach the driver one cycle later; pins are ignored
	a_ramp_step_src: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && !mode.ext_step |=> drv_step == $past(ramp_step)
			&& drv_dir == $past(ramp_dir))
		else $error("driver not fed by ramp generator");

	// Pin step reaches the driver three edges after the pin
	a_pin_step_src: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && mode.ext_step ##1 mode_valid |->
			drv_step == $past(left_ref_or_step_pin, 3))
		else $error("external step not routed");

	// Direction pin feeds the driver, switches read open
	a_pin_dir_src: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && mode.ext_step |=> drv_dir == $past(pins_s.right)
			&& !ref_left && !ref_right)
		else $error("external direction or switch hold wrong");

	// Single-wire port only when both selects are low
	a_uart_select: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid |-> mode.uart_on == (!mode.ext_step && !mode.spi_on)
			&& mode.standalone == (mode.ext_step && !mode.spi_on))
		else $error("host port decode wrong");

	// Straps follow the pins in standalone mode only
	a_strap_route: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && mode.standalone |=> cfg == {$past(pins_s.encb),
			$past(pins_s.sck), $past(pins_s.sdi), $past(pins_s.sdo)}
			&& !serial_out_or_config0_pin_oe)
		else $error("standalone straps wrong or pin driven");

	// Serial out floats when the port is idle
	a_sdo_tristate: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && mode.spi_on |=> serial_out_or_config0_pin_oe == $past(spi_sdo_active)
			&& (!serial_out_or_config0_pin_oe
				|| serial_out_or_config0_pin_out == $past(spi_sdo_data)))
		else $error("serial out tristate wrong");

	// Serial in and clock feed the serial port
	a_sdi_route: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && mode.spi_on |=> spi_sdi == $past(pins_s.sdi)
			&& spi_sck == $past(pins_s.sck) && cfg == MPFS_CFG_RST)
		else $error("serial input routing wrong");

	// Chain address enters on serial in
	a_chain_in: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && mode.uart_on |=> chain_address_in == $past(pins_s.sdi)
			&& !spi_sdi)
		else $error("chain input not routed");

	// Chain address leaves on serial out, always driven
	a_chain_out: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && mode.uart_on |=> serial_out_or_config0_pin_oe
			&& serial_out_or_config0_pin_out == $past(chain_address_out))
		else $error("chain output not driven");

	// Encoder B follows the pin with the ramp generator
	a_encb_route: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && !mode.ext_step |=> encoder_b == $past(pins_s.encb)
			&& !speedctl_enable)
		else $error("encoder B routing wrong");

	// Speed control enable only with pins and serial port
	a_speed_enable: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid ##1 speedctl_enable |-> $past(mode.ext_step) && $past(mode.spi_on)
			&& $past(pins_s.encb))
		else $error("speed control enable outside its mode");

	// Locked mode never moves
	a_mode_static: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid |=> mode_valid && $stable(mode))
		else $error("mode changed after lock");

	// Nothing drives the shared pin before the mode is known
	a_no_early_drive: assert property (@(posedge core_clk) disable iff (reset)
		!mode_valid |=> !serial_out_or_config0_pin_oe)
		else $error("serial out driven before lock");

	// Limit switches follow the pins while the ramp generator steps
	a_ramp_switches: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && !mode.ext_step |=> ref_left == $past(pins_s.left)
			&& ref_right == $past(pins_s.right))
		else $error("limit switch routing wrong");

	// Four-wire port inputs stay quiet while that port is off
	a_spi_gate: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && !mode.spi_on |=> !spi_sdi && !spi_sck)
		else $error("serial port fed while disabled");

	// Chain input stays quiet outside single-wire operation
	a_chain_gate: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && !mode.uart_on |=> !chain_address_in)
		else $error("chain input fed outside single-wire mode");

	// Straps hold their reset value outside standalone operation
	a_strap_gate: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && !mode.standalone |=> cfg == MPFS_CFG_RST)
		else $error("straps fed outside standalone mode");

	// Exactly one host port function once locked
	a_host_onehot: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid |-> $onehot({mode.spi_on, mode.uart_on, mode.standalone}))
		else $error("host port functions overlap");

	// A half-known mode must not move the motor or feed the ports
	a_quiet_unlocked: assert property (@(posedge core_clk) disable iff (reset)
		!mode_valid |=> !drv_step && !drv_dir && !ref_left && !ref_right
			&& !encoder_b && !speedctl_enable && !spi_sdi && !spi_sck
			&& !chain_address_in && cfg == MPFS_CFG_RST)
		else $error("outputs active before lock");

	// Speed control enable stays low without the serial port
	a_speed_gate: assert property (@(posedge core_clk) disable iff (reset)
		mode_valid && !mode.spi_on |=> !speedctl_enable)
		else $error("speed control enable without serial port");

	// Locked mode is the synchronised select levels seen at the lock edge
	a_mode_capture: assert property (@(posedge core_clk) disable iff (reset)
		$rose(mode_valid) |-> mode.ext_step == $past(pins_s.step_sel)
			&& mode.spi_on == $past(pins_s.host_sel))
		else $error("mode not taken from the select pins");

endmodule

// File: sim/mpfs_far_end.sv
// Far-side model: host or external step source driving the shared pins
`timescale 1ns/1ps
module mpfs_far_end
	import mpfs_pkg::*;
(
	input wire logic core_clk, // Device clock
	input wire mpfs_pins_t want, // Levels the far side wants on its pins
	input wire logic sdo_oe, // Device drives the serial out pin
	input wire logic sdo_out, // Device drive value on serial out
	output mpfs_pins_t pins // Resolved pin levels seen by the device
);
	logic float_lvl = 1'h0; // Level shown by a released serial out line
	logic strap_drive; // Far side drives a strap on serial out
	logic sdo_lvl; // Resolved serial out wire

	// No pull on serial out: a released line shows the inverse of the last drive
	always_ff @(posedge core_clk) begin
		float_lvl <= sdo_oe ? ~sdo_out : float_lvl;
	end

	// Strap is only driven where the pin is a configuration input
	assign strap_drive = want.step_sel & ~want.host_sel;
	assign sdo_lvl = sdo_oe ? sdo_out : (strap_drive ? want.sdo : float_lvl);

	// Mode levels pass unchanged; host select low stands for an open pin
	always_comb begin
		pins = want;
		pins.sdo = sdo_lvl;
	end
endmodule

// File: sim/mode_pin_function_select_tb_top.sv
// Self-checking testbench for the mode pin function select block
`timescale 1ns/1ps
module mode_pin_function_select_tb_top;
	import mpfs_pkg::*;

	logic core_clk = 1'h0; // Device clock, 40 MHz
	logic reset = 1'h1; // Asynchronous reset
	mpfs_pins_t want; // Pin levels requested from the far side
	mpfs_pins_t pins; // Resolved pin levels
	logic ramp_step, ramp_dir, spi_sdo_data, spi_sdo_active, chain_out; // Same-clock sources
	logic sdo_out, sdo_oe, drv_step, drv_dir, ref_left, ref_right; // Routed outputs
	logic encoder_b, speedctl_enable, spi_sdi, spi_sck, chain_in, mode_valid; // Routed outputs
	mpfs_cfg_t cfg; // Straps
	mpfs_mode_t mode; // Locked mode
	int mismatches = 0; // Failed comparisons
	int tests_run = 0; // Comparisons made
	int cycles = 0; // Clock cycles for the hang guard

	always #12.5 core_clk = ~core_clk;

	// Whole run is under 130 cycles, so this ceiling only trips on a hang
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			stop_test();
		end
	end

	mpfs_far_end far_end (
		.core_clk(core_clk),
		.want(want),
		.sdo_oe(sdo_oe),
		.sdo_out(sdo_out),
		.pins(pins)
	);

	mpfs_pin_mux dut (
		.core_clk(core_clk),
		.reset(reset),
		.step_source_select(pins.step_sel),
		.host_port_select(pins.host_sel),
		.left_ref_or_step_pin(pins.left),
		.right_ref_or_dir_pin(pins.right),
		.serial_in_or_config1_pin(pins.sdi),
		.serial_clock_or_config2_pin(pins.sck),
		.encoder_b_or_speedctl_enable_pin(pins.encb),
		.serial_out_or_config0_pin_in(pins.sdo),
		.serial_out_or_config0_pin_out(sdo_out),
		.serial_out_or_config0_pin_oe(sdo_oe),
		.ramp_step(ramp_step),
		.ramp_dir(ramp_dir),
		.spi_sdo_data(spi_sdo_data),
		.spi_sdo_active(spi_sdo_active),
		.chain_address_out(chain_out),
		.drv_step(drv_step),
		.drv_dir(drv_dir),
		.ref_left(ref_left),
		.ref_right(ref_right),
		.encoder_b(encoder_b),
		.speedctl_enable(speedctl_enable),
		.spi_sdi(spi_sdi),
		.spi_sck(spi_sck),
		.chain_address_in(chain_in),
		.cfg(cfg),
		.mode(mode),
		.mode_valid(mode_valid)
	);

	// Compare one value and count it
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Report counts, give the verdict and end the run
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Reset with mode pins held, then wait for the lock
	task automatic start_mode(input logic ext, input logic spi);
		int i;
		@(negedge core_clk);
		reset = 1'h1;
		want.step_sel = ext;
		want.host_sel = spi;
		repeat (10) @(negedge core_clk);
		check(sdo_oe, 8'h00);
		check(mode_valid, 8'h00);
		reset = 1'h0;
		for (i = 0; i < 20 && mode_valid !== 1'h1; i++) begin
			@(negedge core_clk);
		end
		check(mode_valid, 8'h01);
		@(negedge core_clk);
		check(mode, {ext, spi, ~ext & ~spi, ext & ~spi});
	endtask

	// Drive pins p = {left,right,sdi,sck,encb,strap}, s = {rstep,rdir,sdata,sact,chain}
	task automatic apply(input logic [5:0] p, input logic [4:0] s, input logic ext,
		input logic spi);
		logic uart;
		logic alone;
		uart = ~ext & ~spi;
		alone = ext & ~spi;
		{want.left, want.right, want.sdi, want.sck, want.encb, want.sdo} = p;
		{ramp_step, ramp_dir, spi_sdo_data, spi_sdo_active, chain_out} = s;
		// Pins take three edges to reach the outputs; one more for margin
		repeat (4) @(negedge core_clk);
		check(drv_step, ext ? p[5] : s[4]);
		check(drv_dir, ext ? p[4] : s[3]);
		check(ref_left, ext ? 1'h0 : p[5]);
		check(ref_right, ext ? 1'h0 : p[4]);
		check(encoder_b, ext ? 1'h0 : p[1]);
		check(speedctl_enable, ext & spi & p[1]);
		check(spi_sdi, spi & p[3]);
		check(spi_sck, spi & p[2]);
		check(chain_in, uart & p[3]);
		check(cfg, alone ? {p[1], p[2], p[3], p[0]} : 4'h0);
		check(sdo_oe, spi ? s[1] : uart);
		if (spi ? s[1] : uart) begin
			check(sdo_out, spi ? s[2] : s[0]);
		end
	endtask

	initial begin
		int m;
		want = '0;
		ramp_step = 1'h0;
		ramp_dir = 1'h0;
		spi_sdo_data = 1'h0;
		spi_sdo_active = 1'h0;
		chain_out = 1'h0;
		// Every mode, three patterns where pins and ramp sources disagree
		for (m = 0; m < 4; m++) begin
			start_mode(m[1], m[0]);
			apply(6'h2D, 5'h0A, m[1], m[0]);
			apply(6'h12, 5'h15, m[1], m[0]);
			// Serial port drives a one so a stuck-low output shows up
			apply(6'h3F, 5'h06, m[1], m[0]);
		end
		// Mode pins moved after lock are ignored
		want.step_sel = 1'h0;
		want.host_sel = 1'h0;
		repeat (8) @(negedge core_clk);
		check(mode, 8'h0C);
		stop_test();
	end
endmodule
